// ===== pkg/softs_map.svh
// Purpose: register offsets, field positions and reset values of the sof tracker
// Assumes: byte addresses on a 32-bit avalon-mm slave
// Notes: included by bare name
`ifndef SOFTS_MAP_SVH
`define SOFTS_MAP_SVH

// ****************
// register offsets
// ****************
`define SOFTS_FRAME_OFS 8'h74
`define SOFTS_SCRATCH_OFS 8'h78

// ****************
// field layout and reset values
// ****************
`define SOFTS_FRAME_LSB 0
`define SOFTS_FRAME_MSB 10
`define SOFTS_MICRO_LSB 11
`define SOFTS_MICRO_MSB 13
`define SOFTS_TOP_LSB 14
`define SOFTS_TOP_MSB 31
`define SOFTS_LANE0_LSB 0
`define SOFTS_LANE0_MSB 7
`define SOFTS_LANE1_LSB 8
`define SOFTS_LANE1_MSB 15
`define SOFTS_WAIT_STATES 4'h1
`define SOFTS_WAIT_CNT_RST 4'h0
`define SOFTS_FRAME_RST 11'h000
`define SOFTS_MICRO_RST 3'h0
`define SOFTS_SCRATCH_RST 16'h0000
`define SOFTS_UNMAPPED_RD 32'h0000_0000

`endif

// ===== pkg/softs_pkg.sv
// Purpose: shared types of the sof tracker
// Assumes: nothing
// Notes: constants live in softs_map.svh
package softs_pkg;
    // ****************
    // types
    // ****************
    typedef enum logic [1:0] {
        SOFTS_SEL_NONE,
        SOFTS_SEL_FRAME,
        SOFTS_SEL_SCRATCH
    } softs_sel_t;
endpackage

// ===== hdl/softs_tracker.sv
// Purpose: last sof frame/microframe capture plus a firmware scratch register
// Assumes: sof decoder gives a one-cycle strobe for each sof that passed its checks
// Notes: avalon-mm slave, one wait state on every access
`timescale 1ns/10ps
`include "softs_map.svh"

module softs_tracker (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // sof decoder side
    input wire logic sof_valid,
    input wire logic [10:0] received_frame_count,
    input wire logic [2:0] microframe_index,
    // usb state, not used to clear anything here
    input wire logic usb_bus_reset,
    input wire logic suspend
);

    // ****************
    // address decode
    // ****************
    function automatic softs_pkg::softs_sel_t softs_decode(input logic [7:0] addr);
        softs_pkg::softs_sel_t sel;
        sel = softs_pkg::SOFTS_SEL_NONE;
        if (addr == `SOFTS_FRAME_OFS) begin
            sel = softs_pkg::SOFTS_SEL_FRAME;
        end else if (addr == `SOFTS_SCRATCH_OFS) begin
            sel = softs_pkg::SOFTS_SEL_SCRATCH;
        end
        return sel;
    endfunction

    // ****************
    // read word packing
    // ****************
    // frame word: reserved bits stay zero, fields placed by their field macros
    function automatic logic [31:0] softs_frame_word(input logic [2:0] micro,
        input logic [10:0] frame);
        logic [31:0] w;
        w = `SOFTS_UNMAPPED_RD;
        w[`SOFTS_FRAME_MSB:`SOFTS_FRAME_LSB] = frame;
        w[`SOFTS_MICRO_MSB:`SOFTS_MICRO_LSB] = micro;
        return w;
    endfunction

    // scratch word: upper half of the bus word always reads zero
    function automatic logic [31:0] softs_scratch_word(input logic [15:0] scr);
        logic [31:0] w;
        w = `SOFTS_UNMAPPED_RD;
        w[`SOFTS_LANE1_MSB:`SOFTS_LANE0_LSB] = scr;
        return w;
    endfunction

    // byte-lane merge: only lanes 0 and 1 land, lanes 2 and 3 are dropped
    function automatic logic [15:0] softs_merge(input logic [15:0] old,
        input logic [31:0] wd, input logic [3:0] be);
        logic [15:0] n;
        n = old;
        if (be[0]) begin
            n[`SOFTS_LANE0_MSB:`SOFTS_LANE0_LSB] = wd[`SOFTS_LANE0_MSB:`SOFTS_LANE0_LSB];
        end
        if (be[1]) begin
            n[`SOFTS_LANE1_MSB:`SOFTS_LANE1_LSB] = wd[`SOFTS_LANE1_MSB:`SOFTS_LANE1_LSB];
        end
        return n;
    endfunction

    logic [10:0] frame_q;
    logic [2:0] micro_q;
    logic [15:0] scratch_q;
    logic ack_q;
    logic [31:0] rdata_q;
    softs_pkg::softs_sel_t sel;
    logic req;
    logic wr_fire;

    assign sel = softs_decode(avs_address);
    assign req = avs_read | avs_write;
    assign wr_fire = avs_write & ack_q;

    // ****************
    // bus handshake
    // ****************
    // one wait state: ack pulses the cycle after a request is seen
    // cycle 0: read or write raised, waitrequest high, ack_q loads on the edge
    // cycle 1: waitrequest low, read word stands, a write lands on the edge
    // cycle 2: ack_q back to zero, so a held request starts a fresh access
    // hazard: waitrequest is combinational from the request, so a master
    // must not raise a request in reaction to waitrequest in the same cycle
    // trade: a fixed wait state costs one cycle but registers the read word
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    assign avs_waitrequest = req & ~ack_q; // low in the ack cycle and whenever no request is raised

    // read data captured in the wait cycle, stands in the ack cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= `SOFTS_UNMAPPED_RD;
        end else if (avs_read & ~ack_q) begin
            case (sel)
                softs_pkg::SOFTS_SEL_FRAME: begin
                    rdata_q <= softs_frame_word(micro_q, frame_q);
                end
                softs_pkg::SOFTS_SEL_SCRATCH: begin
                    rdata_q <= softs_scratch_word(scratch_q);
                end
                default: begin
                    rdata_q <= `SOFTS_UNMAPPED_RD;
                end
            endcase
        end
    end

    assign avs_readdata = rdata_q;

    // ****************
    // usb state inputs
    // ****************
    // bus reset and suspend reach this block only so that the assertions can
    // show that neither touches the scratch word; firmware relies on the
    // scratch word surviving both, and the frame fields simply keep their
    // last sof until the next good one arrives
    // note: there is no write protection during suspend; scratch writes land as at any other time

    // ****************
    // sof capture
    // ****************
    // fields load only on a good sof; bus writes never reach them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frame_q <= `SOFTS_FRAME_RST;
            micro_q <= `SOFTS_MICRO_RST;
        end else if (sof_valid) begin
            frame_q <= received_frame_count;
            micro_q <= microframe_index;
        end
    end

    // ****************
    // scratch register
    // ****************
    // bus reset and suspend are deliberately ignored here
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scratch_q <= `SOFTS_SCRATCH_RST;
        end else if (wr_fire && sel == softs_pkg::SOFTS_SEL_SCRATCH) begin
            scratch_q <= softs_merge(scratch_q, avs_writedata, avs_byteenable);
        end
    end

    // ****************
    // assertions
    // ****************
    a_frame_load: assert property (@(posedge clk) disable iff (rst)
        sof_valid |=> frame_q == $past(received_frame_count))
        else $error("frame number not captured");
    a_micro_load: assert property (@(posedge clk) disable iff (rst)
        sof_valid |=> micro_q == $past(microframe_index))
        else $error("microframe not captured");
    a_frame_hold: assert property (@(posedge clk) disable iff (rst)
        !sof_valid |=> $stable(frame_q) && $stable(micro_q))
        else $error("frame register changed without sof");
    a_frame_read: assert property (@(posedge clk) disable iff (rst)
        (avs_read && !ack_q && sel == softs_pkg::SOFTS_SEL_FRAME)
        |=> avs_readdata == {18'h00000, $past(micro_q), $past(frame_q)})
        else $error("frame read data wrong");
    a_scratch_write: assert property (@(posedge clk) disable iff (rst)
        (wr_fire && sel == softs_pkg::SOFTS_SEL_SCRATCH && avs_byteenable[1:0] == 2'h3)
        |=> scratch_q == $past(avs_writedata[15:0]))
        else $error("scratch write lost");
    a_scratch_keep: assert property (@(posedge clk) disable iff (rst)
        !(wr_fire && sel == softs_pkg::SOFTS_SEL_SCRATCH) |=> $stable(scratch_q))
        else $error("scratch changed without write");
    a_scratch_busrst: assert property (@(posedge clk) disable iff (rst)
        (usb_bus_reset && !avs_write) |=> $stable(scratch_q))
        else $error("scratch disturbed by bus reset");
    a_scratch_read: assert property (@(posedge clk) disable iff (rst)
        (avs_read && !ack_q && sel == softs_pkg::SOFTS_SEL_SCRATCH)
        |=> avs_readdata == {16'h0000, $past(scratch_q)})
        else $error("scratch read data wrong");
    a_wait_bound: assert property (@(posedge clk) disable iff (rst)
        (req && avs_waitrequest) |=> !avs_waitrequest)
        else $error("waitrequest held too long");

    // ****************
    // assertion helpers
    // ****************
    // counts waitrequest-high cycles; one wait state means it never passes one
    logic [3:0] wait_cnt_q;
    logic [3:0] wait_cnt_d;

    assign wait_cnt_d = avs_waitrequest ? wait_cnt_q + 4'h1 : `SOFTS_WAIT_CNT_RST;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_cnt_q <= `SOFTS_WAIT_CNT_RST;
        end else begin
            wait_cnt_q <= wait_cnt_d;
        end
    end

    // ****************
    // bus timing assertions
    // ****************
    // every request opens with waitrequest high
    a_wait_first: assert property (@(posedge clk) disable iff (rst)
        (req && !ack_q) |-> avs_waitrequest)
        else $error("request answered without a wait state");

    // an idle bus never sees waitrequest
    a_wait_idle: assert property (@(posedge clk) disable iff (rst)
        !req |-> !avs_waitrequest)
        else $error("waitrequest high on idle bus");

    // ack lasts exactly one cycle
    a_ack_pulse: assert property (@(posedge clk) disable iff (rst)
        ack_q |=> !ack_q)
        else $error("ack longer than one cycle");

    // no access waits more than the fixed wait state
    a_wait_count: assert property (@(posedge clk) disable iff (rst)
        wait_cnt_q <= `SOFTS_WAIT_STATES)
        else $error("more wait states than expected");

    // read word moves only on a read capture edge
    a_rdata_hold: assert property (@(posedge clk) disable iff (rst)
        !(avs_read && !ack_q) |=> $stable(avs_readdata))
        else $error("read data moved without a read");

    // ****************
    // register content assertions
    // ****************
    // unmapped reads give the fixed zero word
    a_unmapped_read: assert property (@(posedge clk) disable iff (rst)
        (avs_read && !ack_q && sel == softs_pkg::SOFTS_SEL_NONE)
        |=> avs_readdata == `SOFTS_UNMAPPED_RD)
        else $error("unmapped read not zero");

    // reserved frame bits read zero
    a_frame_top_zero: assert property (@(posedge clk) disable iff (rst)
        (avs_read && !ack_q && sel == softs_pkg::SOFTS_SEL_FRAME)
        |=> avs_readdata[`SOFTS_TOP_MSB:`SOFTS_TOP_LSB] == 18'h00000)
        else $error("reserved frame bits not zero");

    // bus writes never reach the frame fields
    a_frame_wr_ignored: assert property (@(posedge clk) disable iff (rst)
        (avs_write && sel == softs_pkg::SOFTS_SEL_FRAME && !sof_valid)
        |=> $stable(frame_q) && $stable(micro_q))
        else $error("frame register took a write");

    // suspend alone leaves the scratch word alone
    a_scratch_suspend: assert property (@(posedge clk) disable iff (rst)
        (suspend && !(wr_fire && sel == softs_pkg::SOFTS_SEL_SCRATCH))
        |=> $stable(scratch_q))
        else $error("scratch disturbed in suspend");

    // lower byte follows lane 0
    a_lane_low: assert property (@(posedge clk) disable iff (rst)
        (wr_fire && sel == softs_pkg::SOFTS_SEL_SCRATCH && avs_byteenable[0])
        |=> scratch_q[7:0] == $past(avs_writedata[7:0]))
        else $error("scratch lower byte lost");

    // upper byte follows lane 1
    a_lane_high: assert property (@(posedge clk) disable iff (rst)
        (wr_fire && sel == softs_pkg::SOFTS_SEL_SCRATCH && avs_byteenable[1])
        |=> scratch_q[15:8] == $past(avs_writedata[15:8]))
        else $error("scratch upper byte lost");

    // scratch read leaves the upper bus half zero
    a_scratch_top_zero: assert property (@(posedge clk) disable iff (rst)
        (avs_read && !ack_q && sel == softs_pkg::SOFTS_SEL_SCRATCH)
        |=> avs_readdata[31:16] == 16'h0000)
        else $error("scratch upper half not zero");

    // ****************
    // cover properties
    // ****************
    c_sof_seen: cover property (@(posedge clk) disable iff (rst) sof_valid);
    c_scratch_wr: cover property (@(posedge clk) disable iff (rst)
        wr_fire && sel == softs_pkg::SOFTS_SEL_SCRATCH);
    c_frame_rd: cover property (@(posedge clk) disable iff (rst)
        avs_read && ack_q && sel == softs_pkg::SOFTS_SEL_FRAME);
    c_suspend_keep: cover property (@(posedge clk) disable iff (rst)
        suspend && scratch_q != `SOFTS_SCRATCH_RST);
    c_unmapped_rd: cover property (@(posedge clk) disable iff (rst)
        avs_read && ack_q && sel == softs_pkg::SOFTS_SEL_NONE);

endmodule // softs_tracker

// ===== test/softs_sof_host.sv
// Purpose: host side model issuing sof strobes
// Assumes: one strobe cycle per good sof
// Notes: fields are inverted between strobes
`timescale 1ns/10ps
module softs_sof_host (
    // clock
    input wire logic clk,
    // sof strobe and fields
    output logic sof_valid,
    output logic [10:0] received_frame_count,
    output logic [2:0] microframe_index
);
    // idle at time zero
    initial begin
        sof_valid = 1'b0;
        received_frame_count = 11'h000;
        microframe_index = 3'h0;
    end
    // one sof after gap + 1 idle cycles, fields stale afterwards
    task send(input logic [10:0] f, input logic [2:0] m, input int gap);
        repeat (gap + 1) @(posedge clk);
        sof_valid <= 1'b1;
        received_frame_count <= f;
        microframe_index <= m;
        @(posedge clk);
        sof_valid <= 1'b0;
        received_frame_count <= ~f;
        microframe_index <= ~m;
    endtask
endmodule // softs_sof_host

// ===== test/sof_frame_tracker_scratch_tb.sv
// Purpose: self-checking bench of the sof tracker
// Assumes: one wait state per access
// Notes: scratch model kept in scr
`timescale 1ns/10ps
`include "softs_map.svh"
module sof_frame_tracker_scratch_tb;
    logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic usb_bus_reset = 1'b0, suspend = 1'b0, avs_waitrequest, sof_valid;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [3:0] avs_byteenable = 4'h0;
    logic [10:0] received_frame_count, f;
    logic [2:0] microframe_index, m;
    logic [15:0] scr = 16'h0000;
    integer seed = 93, fail_count = 0, n_tests = 0, i;
    // clock
    always #25 clk = ~clk;
    softs_tracker u_softs_tracker (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sof_valid(sof_valid),
        .received_frame_count(received_frame_count), .microframe_index(microframe_index),
        .usb_bus_reset(usb_bus_reset), .suspend(suspend));
    softs_sof_host u_softs_sof_host (.clk(clk), .sof_valid(sof_valid),
        .received_frame_count(received_frame_count), .microframe_index(microframe_index));
    // verdict and end of run
    task end_sim;
        $display("tests %0d fails %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // compare seen against expected
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    // one avalon access, held until waitrequest low
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        integer n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        avs_byteenable <= be;
        // sample between edges: the values stand until the next rising edge
        while (!done) begin
            @(negedge clk);
            done = (avs_waitrequest === 1'b0);
            rd = avs_readdata;
            n++;
            if (n > 20) begin
                fail_count++;
                end_sim;
            end
            @(posedge clk);
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // watchdog
    initial begin
        #2000000;
        fail_count++;
        end_sim;
    end
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        bus(0, `SOFTS_FRAME_OFS, 0, 4'hf);
        chk(rd, 32'h0);
        bus(0, `SOFTS_SCRATCH_OFS, 0, 4'hf);
        chk(rd, 32'h0);
        $display("test 1 done");
        // scratch lanes while bus reset and suspend wander
        for (i = 0; i < 8; i++) begin
            usb_bus_reset <= $random(seed);
            suspend <= $random(seed);
            bus(1, `SOFTS_SCRATCH_OFS, $random(seed), $random(seed));
            if (avs_byteenable[0]) scr[7:0] = avs_writedata[7:0];
            if (avs_byteenable[1]) scr[15:8] = avs_writedata[15:8];
            bus(0, `SOFTS_SCRATCH_OFS, 0, 4'hf);
            chk(rd, {16'h0, scr});
        end
        $display("test 2 done");
        // frame write ignored, unmapped read zero
        bus(1, `SOFTS_FRAME_OFS, 32'hffff_ffff, 4'hf);
        bus(0, `SOFTS_FRAME_OFS, 0, 4'hf);
        chk(rd, 32'h0);
        bus(0, 8'h7c, 0, 4'hf);
        chk(rd, 32'h0);
        // sof capture, last one of close pairs wins
        for (i = 0; i < 6; i++) begin
            f = $random(seed);
            m = $random(seed);
            u_softs_sof_host.send(~f, ~m, i % 2);
            u_softs_sof_host.send(f, m, 0);
            bus(0, `SOFTS_FRAME_OFS, 0, 4'hf);
            chk(rd, {18'h0, m, f});
        end
        suspend <= 1'b1;
        bus(0, `SOFTS_SCRATCH_OFS, 0, 4'hf);
        chk(rd, {16'h0, scr});
        $display("test 3 done");
        // reset in mid-run clears both registers
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        scr = 16'h0000;
        bus(0, `SOFTS_SCRATCH_OFS, 0, 4'hf);
        chk(rd, 32'h0);
        bus(0, `SOFTS_FRAME_OFS, 0, 4'hf);
        chk(rd, 32'h0);
        $display("test 4 done");
        end_sim;
    end
endmodule // sof_frame_tracker_scratch_tb
